// File: rtl/ier_readout.sv
`timescale 1ns/1ps
// Contract
// - pixels numbered column by column, 1 to 324
// - each sample is unsigned 0 to 63
// - gain loop keeps brightest pixel mid fifties
// - exposure tracks average and maximum, per frame
// - exposure read as high and low bytes
// - exposure in clock cycles, resets to 0x0100
// - each change steps by one sixteenth, or up to the cap or down to the 0x0010 floor when a full step would pass it
// - exposure capped at clock/rate minus 3476
// - default cap 12397 cycles, 0x306D
// - type register returns inverted id nibble
// - dump write restarts pointer at pixel 1
// - dump byte: start flag, valid flag, sample
// - at most one dumped pixel per frame
module ier_readout #(
    parameter int         OSC_HZ     = ier_pkg::OSC_HZ_DEF,
    parameter int         FRAME_RATE = ier_pkg::FRAME_RATE_DEF,
    parameter logic [3:0] TYPE_ID    = 4'h5 // arbitrary value
) (
    input  wire logic                        clock_in,
    input  wire logic                        rst_in,
    input  wire logic                        sck_in,
    input  wire logic                        sdio_in,
    output logic                             sdio_out,
    output logic                             sdio_oe_n_out,
    input  wire logic                        frame_start_in,
    input  wire logic                        pix_valid_in,
    input  wire logic [ier_pkg::SAMPLE_W-1:0] pix_value_in,
    output logic [15:0]                      exposure_out
);
    import ier_pkg::*;

    localparam logic [15:0] EXP_MAX = 16'(OSC_HZ / FRAME_RATE - EXP_SUBTRACT);

    logic [6:0]          reg_addr;
    logic                wr_pulse, rd_pulse;
    logic [7:0]          wr_data;
    logic [7:0]          rd_data_r, rd_data_nxt;
    logic [15:0]         exposure_r, exposure_nxt;
    logic [7:0]          low_shadow_r, low_shadow_nxt;
    logic [8:0]          idx_r, idx_nxt, cur_idx;
    logic [5:0]          max_r, max_nxt, fmax;
    logic [14:0]         sum_r, sum_nxt, fsum;
    logic [8:0]          ptr_r, ptr_nxt;
    logic                armed_r, armed_nxt, valid_r, valid_nxt, taken_r, taken_nxt, taken_eff;
    logic [SAMPLE_W-1:0] grab_r, grab_nxt;
    logic                frame_end, grab;
    logic [15:0]         step, dn;
    logic [16:0]         up;

    // ****************************************************
    // serial port
    // ****************************************************
    ier_serial_port u_port (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .sck_in        (sck_in),
        .sdio_in       (sdio_in),
        .sdio_out      (sdio_out),
        .sdio_oe_n_out (sdio_oe_n_out),
        .reg_addr_out  (reg_addr),
        .wr_pulse_out  (wr_pulse),
        .wr_data_out   (wr_data),
        .rd_pulse_out  (rd_pulse),
        .rd_data_in    (rd_data_r)
    );

    // ****************************************************
    // frame statistics and gain loop
    // ****************************************************
    always_comb begin
        cur_idx   = frame_start_in ? 9'h000 : idx_r;
        fmax      = (frame_start_in || pix_value_in > max_r) ? pix_value_in : max_r;
        fsum      = 15'((frame_start_in ? 15'h0000 : sum_r) + 15'(pix_value_in));
        frame_end = pix_valid_in && (cur_idx == 9'(PIX_COUNT - 9'h001));
        idx_nxt   = idx_r;
        max_nxt   = max_r;
        sum_nxt   = sum_r;
        if (pix_valid_in) begin
            idx_nxt = (cur_idx == PIX_COUNT) ? cur_idx : 9'(cur_idx + 9'h001);
            max_nxt = fmax;
            sum_nxt = fsum;
        end
        step         = exposure_r >> EXP_STEP_SHIFT;
        up           = 17'(exposure_r) + 17'(step);
        dn           = 16'(exposure_r - step);
        exposure_nxt = exposure_r;
        if (frame_end) begin
            if (fmax > AGC_MAX_HI || fsum > AGC_SUM_HI) begin
                exposure_nxt = (dn < EXP_MIN) ? EXP_MIN : dn;
            end else if (fmax < AGC_MAX_LO && fsum < AGC_SUM_HI) begin
                exposure_nxt = (up > 17'(EXP_MAX)) ? EXP_MAX : up[15:0];
            end
        end
    end

    // ****************************************************
    // pixel dump and register reads
    // ****************************************************
    always_comb begin
        taken_eff      = frame_start_in ? 1'b0 : taken_r;
        grab           = armed_r && !taken_eff && pix_valid_in && (cur_idx == ptr_r);
        ptr_nxt        = ptr_r;
        armed_nxt      = armed_r;
        valid_nxt      = valid_r;
        grab_nxt       = grab_r;
        taken_nxt      = taken_eff;
        low_shadow_nxt = low_shadow_r;
        rd_data_nxt    = rd_data_r;
        if (rd_pulse) begin
            case (reg_addr)
                ADDR_PIXEL_DUMP: begin
                    rd_data_nxt                 = 8'h00;
                    rd_data_nxt[DUMP_SOF_BIT]   = (ptr_r == 9'h000);
                    rd_data_nxt[DUMP_VALID_BIT] = valid_r;
                    rd_data_nxt[SAMPLE_W-1:0]   = grab_r;
                    armed_nxt                   = 1'b1;
                    if (valid_r) begin
                        valid_nxt = 1'b0;
                        ptr_nxt   = (ptr_r == 9'(PIX_COUNT - 9'h001)) ? 9'h000 : 9'(ptr_r + 9'h001);
                    end
                end
                ADDR_EXP_HIGH: begin
                    rd_data_nxt    = exposure_r[15:8];
                    low_shadow_nxt = exposure_r[7:0];
                end
                ADDR_EXP_LOW: begin
                    rd_data_nxt = low_shadow_r;
                end
                ADDR_TYPE: begin
                    rd_data_nxt = {TYPE_RESERVED, ~TYPE_ID};
                end
                default: begin
                    rd_data_nxt = 8'h00;
                end
            endcase
        end
        if (grab) begin
            grab_nxt  = pix_value_in;
            valid_nxt = 1'b1;
            armed_nxt = 1'b0;
            taken_nxt = 1'b1;
        end
        // write wins over a grab in the same cycle
        if (wr_pulse && reg_addr == ADDR_PIXEL_DUMP) begin
            ptr_nxt   = 9'h000;
            valid_nxt = 1'b0;
            armed_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            exposure_r   <= EXP_RESET;
            low_shadow_r <= 8'h00;
            idx_r        <= 9'h000;
            max_r        <= 6'h00;
            sum_r        <= 15'h0000;
            ptr_r        <= 9'h000;
            armed_r      <= 1'b0;
            valid_r      <= 1'b0;
            taken_r      <= 1'b0;
            grab_r       <= 6'h00;
            rd_data_r    <= 8'h00;
        end else begin
            exposure_r   <= exposure_nxt;
            low_shadow_r <= low_shadow_nxt;
            idx_r        <= idx_nxt;
            max_r        <= max_nxt;
            sum_r        <= sum_nxt;
            ptr_r        <= ptr_nxt;
            armed_r      <= armed_nxt;
            valid_r      <= valid_nxt;
            taken_r      <= taken_nxt;
            grab_r       <= grab_nxt;
            rd_data_r    <= rd_data_nxt;
        end
    end

    assign exposure_out = exposure_r;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    sequence s_dump_write;
        wr_pulse && reg_addr == ADDR_PIXEL_DUMP;
    endsequence
    sequence s_dump_read;
        rd_pulse && reg_addr == ADDR_PIXEL_DUMP;
    endsequence

    a_exp_after_reset: assert property ($past(rst_in) |-> exposure_r == EXP_RESET)
        else $error("exposure not at reset value");
    a_exp_ceiling: assert property (exposure_r <= EXP_MAX && exposure_r >= EXP_MIN)
        else $error("exposure outside limits");
    a_exp_step_size: assert property ($changed(exposure_r) |->
        (exposure_r == $past(exposure_r) + ($past(exposure_r) >> 4)) ||
        (exposure_r == $past(exposure_r) - ($past(exposure_r) >> 4)) ||
        exposure_r == EXP_MAX || exposure_r == EXP_MIN)
        else $error("exposure step not one sixteenth");
    a_exp_frame_only: assert property ($changed(exposure_r) |-> $past(frame_end))
        else $error("exposure changed off frame end");
    a_agc_bright_down: assert property (frame_end && fmax > AGC_MAX_HI && exposure_r > EXP_MIN
        |=> exposure_r < $past(exposure_r))
        else $error("bright frame did not shorten exposure");
    a_low_capture: assert property (rd_pulse && reg_addr == ADDR_EXP_HIGH
        |=> low_shadow_r == $past(exposure_r[7:0]) && rd_data_r == $past(exposure_r[15:8]))
        else $error("exposure byte pair not coherent");
    a_dump_restart: assert property (s_dump_write |=> ptr_r == 9'h000 && !valid_r ##0 armed_r)
        else $error("dump write did not restart pointer");
    a_dump_sof: assert property (s_dump_write ##[1:300] s_dump_read
        |=> rd_data_r[DUMP_SOF_BIT] == ($past(ptr_r) == 9'h000))
        else $error("start flag wrong");
    a_one_per_frame: assert property (grab |=> (!grab throughout (!frame_start_in)[*8]) or
        (##[0:7] frame_start_in))
        else $error("second pixel in one frame");
    a_ptr_range: assert property (ptr_r < PIX_COUNT)
        else $error("pixel pointer out of range");
    a_type_read: assert property (rd_pulse && reg_addr == ADDR_TYPE
        |=> rd_data_r == {TYPE_RESERVED, ~TYPE_ID})
        else $error("type register wrong");
endmodule // ier_readout

// File: rtl/ier_pkg.sv
// ****************************************************
// constants of the image exposure readout
// ****************************************************
package ier_pkg;
    // register offsets, seven address bits
    localparam logic [6:0]  ADDR_PIXEL_DUMP = 7'h08;
    localparam logic [6:0]  ADDR_EXP_HIGH   = 7'h0E;
    localparam logic [6:0]  ADDR_EXP_LOW    = 7'h0F;
    localparam logic [6:0]  ADDR_TYPE       = 7'h11;
    // pixel array
    localparam int          ARRAY_DIM       = 18;
    localparam logic [8:0]  PIX_COUNT       = 9'h144;
    localparam int          SAMPLE_W        = 6;
    // dump register fields
    localparam int          DUMP_SOF_BIT    = 7;
    localparam int          DUMP_VALID_BIT  = 6;
    // type register
    localparam logic [3:0]  TYPE_RESERVED   = 4'hF;
    // exposure
    localparam logic [15:0] EXP_RESET       = 16'h0100;
    localparam logic [15:0] EXP_MIN         = 16'h0010;
    localparam int          EXP_STEP_SHIFT  = 4;
    localparam int          EXP_SUBTRACT    = 3476;
    localparam int          OSC_HZ_DEF      = 24000000;
    localparam int          FRAME_RATE_DEF  = 1512;
    // gain loop targets
    localparam logic [5:0]  AGC_MAX_HI      = 6'h39;
    localparam logic [5:0]  AGC_MAX_LO      = 6'h34;
    localparam logic [14:0] AGC_SUM_HI      = 15'h3F48;
    // serial frame
    localparam logic [2:0]  SER_LAST_BIT    = 3'h7;
    // serial port states
    typedef enum logic [2:0] {
        IER_ST_ADDR  = 3'b001,
        IER_ST_WDATA = 3'b010,
        IER_ST_RDATA = 3'b100
    } ier_ser_state_e;
endpackage

// File: rtl/ier_serial_port.sv
`timescale 1ns/1ps
// ****************************************************
// two-wire serial register port
// ****************************************************
module ier_serial_port (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        sck_in,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe_n_out,
    output logic [6:0]       reg_addr_out,
    output logic             wr_pulse_out,
    output logic [7:0]       wr_data_out,
    output logic             rd_pulse_out,
    input  wire logic [7:0]  rd_data_in
);
    import ier_pkg::*;

    logic           sck_s1_r, sck_s2_r, sck_prev_r, sdio_s1_r, sdio_s2_r;
    ier_ser_state_e state_r, state_nxt;
    logic [2:0]     cnt_r, cnt_nxt;
    logic [7:0]     shift_r, shift_nxt;
    logic [6:0]     addr_r, addr_nxt;
    logic [7:0]     wdata_r, wdata_nxt;
    logic           wr_r, wr_nxt, rd_r, rd_nxt, sdio_r, sdio_nxt, oe_n_r, oe_n_nxt;
    logic           rise, fall;

    assign rise = sck_s2_r & ~sck_prev_r;
    assign fall = ~sck_s2_r & sck_prev_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        wr_nxt    = 1'b0;
        rd_nxt    = 1'b0;
        sdio_nxt  = sdio_r;
        oe_n_nxt  = oe_n_r;
        case (state_r)
            IER_ST_ADDR: begin
                if (rise) begin
                    shift_nxt = {shift_r[6:0], sdio_s2_r};
                    cnt_nxt   = 3'(cnt_r + 3'h1);
                    if (cnt_r == SER_LAST_BIT) begin
                        addr_nxt = {shift_r[5:0], sdio_s2_r};
                        if (shift_r[6]) begin
                            state_nxt = IER_ST_WDATA;
                        end else begin
                            state_nxt = IER_ST_RDATA;
                            rd_nxt    = 1'b1;
                        end
                    end
                end
            end
            IER_ST_WDATA: begin
                if (rise) begin
                    shift_nxt = {shift_r[6:0], sdio_s2_r};
                    cnt_nxt   = 3'(cnt_r + 3'h1);
                    if (cnt_r == SER_LAST_BIT) begin
                        wdata_nxt = {shift_r[6:0], sdio_s2_r};
                        wr_nxt    = 1'b1;
                        state_nxt = IER_ST_ADDR;
                    end
                end
            end
            IER_ST_RDATA: begin
                if (fall) begin
                    if (oe_n_r) begin
                        sdio_nxt  = rd_data_in[7];
                        shift_nxt = {rd_data_in[6:0], 1'b0};
                        oe_n_nxt  = 1'b0;
                    end else begin
                        sdio_nxt  = shift_r[7];
                        shift_nxt = {shift_r[6:0], 1'b0};
                    end
                end
                if (rise && !oe_n_r) begin
                    cnt_nxt = 3'(cnt_r + 3'h1);
                    if (cnt_r == SER_LAST_BIT) begin
                        state_nxt = IER_ST_ADDR;
                        oe_n_nxt  = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = IER_ST_ADDR;
                cnt_nxt   = 3'h0;
                oe_n_nxt  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            // sck idles high: no false rise after reset
            sck_s1_r   <= 1'b1;
            sck_s2_r   <= 1'b1;
            sck_prev_r <= 1'b1;
            sdio_s1_r  <= 1'b0;
            sdio_s2_r  <= 1'b0;
            state_r    <= IER_ST_ADDR;
            cnt_r      <= 3'h0;
            shift_r    <= 8'h00;
            addr_r     <= 7'h00;
            wdata_r    <= 8'h00;
            wr_r       <= 1'b0;
            rd_r       <= 1'b0;
            sdio_r     <= 1'b0;
            oe_n_r     <= 1'b1;
        end else begin
            sck_s1_r   <= sck_in;
            sck_s2_r   <= sck_s1_r;
            sck_prev_r <= sck_s2_r;
            sdio_s1_r  <= sdio_in;
            sdio_s2_r  <= sdio_s1_r;
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            shift_r    <= shift_nxt;
            addr_r     <= addr_nxt;
            wdata_r    <= wdata_nxt;
            wr_r       <= wr_nxt;
            rd_r       <= rd_nxt;
            sdio_r     <= sdio_nxt;
            oe_n_r     <= oe_n_nxt;
        end
    end

    assign sdio_out      = sdio_r;
    assign sdio_oe_n_out = oe_n_r;
    assign reg_addr_out  = addr_r;
    assign wr_pulse_out  = wr_r;
    assign wr_data_out   = wdata_r;
    assign rd_pulse_out  = rd_r;
endmodule // ier_serial_port

// File: verification/ier_host_model.sv
`timescale 1ns/1ps
// ****************************************************
// host controller on the two-wire serial port
// ****************************************************
module ier_host_model
    import ier_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic sdio_in,
    output logic      sck_out,
    output logic      sdio_out
);
    initial begin
        sck_out  = 1'b1;
        sdio_out = 1'b0;
    end

    // one serial period: data set while low, sampled at the rise
    task automatic bit_cycle(input logic b, output logic r);
        @(posedge clock_in);
        sck_out  <= 1'b0;
        sdio_out <= b;
        repeat (4) @(posedge clock_in);
        r = sdio_in;
        sck_out <= 1'b1;
        repeat (3) @(posedge clock_in);
    endtask

    // address byte, then data byte; idle clock stays high
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rd);
        logic [7:0] a;
        logic       r;
        a = {wr, addr};
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(a[i], r);
        end
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(wr ? wd[i] : ~sdio_out, r);
            rd[i] = r;
        end
        repeat (8) @(posedge clock_in);
        sdio_out <= ~sdio_out;
    endtask

    // high byte first, low byte straight after
    task automatic read_exposure(output logic [7:0] hi, output logic [7:0] lo);
        xfer(1'b0, ADDR_EXP_HIGH, 8'h00, hi);
        xfer(1'b0, ADDR_EXP_LOW, 8'h00, lo);
    endtask
endmodule // ier_host_model

// File: verification/testbench.sv
`timescale 1ns/1ps
// ****************************************************
// bench of the image exposure readout
// ****************************************************
module testbench;
    import ier_pkg::*;
    localparam int         CAP     = OSC_HZ_DEF / FRAME_RATE_DEF - EXP_SUBTRACT;
    localparam logic [3:0] TYPE_ID = 4'h5; // arbitrary value
    logic        clock_in    = 1'b0;
    logic        rst_in      = 1'b1;
    logic        frame_start = 1'b0;
    logic        pix_valid   = 1'b0;
    logic [5:0]  pix_value   = 6'h00;
    logic        dut_sdio;
    logic        sdio_oe_n;
    logic        host_sck;
    logic        host_sdio;
    logic        sdio_wire;
    logic [15:0] exposure;
    logic [15:0] exp_model;
    logic [15:0] old_exp;
    logic [7:0]  d;
    logic [7:0]  hi;
    logic [7:0]  lo;
    int          n_fail      = 0;
    int          comparisons = 0;
    int          seed        = 25217;
    int          hold;

    always #5 clock_in = ~clock_in;
    assign sdio_wire = sdio_oe_n ? host_sdio : dut_sdio;

    ier_readout #(.TYPE_ID(TYPE_ID)) u_ier_readout (
        .clock_in(clock_in), .rst_in(rst_in), .sck_in(host_sck), .sdio_in(sdio_wire),
        .sdio_out(dut_sdio), .sdio_oe_n_out(sdio_oe_n), .frame_start_in(frame_start),
        .pix_valid_in(pix_valid), .pix_value_in(pix_value), .exposure_out(exposure)
    );

    ier_host_model u_ier_host_model (
        .clock_in(clock_in), .sdio_in(sdio_wire), .sck_out(host_sck), .sdio_out(host_sdio)
    );

    // ****************************************************
    // expectations and checks
    // ****************************************************
    function automatic logic [15:0] agc_step(input logic [15:0] v, input int mx, input int sum);
        logic [15:0] s;
        s = v >> EXP_STEP_SHIFT;
        if (mx > AGC_MAX_HI || sum > AGC_SUM_HI) return (v - s < EXP_MIN) ? EXP_MIN : v - s;
        if (mx < AGC_MAX_LO && sum < AGC_SUM_HI) return (int'(v + s) > CAP) ? 16'(CAP) : v + s;
        return v;
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check_regs();
        u_ier_host_model.read_exposure(hi, lo);
        check("exposure bytes", exp_model, {hi, lo});
    endtask

    // one frame of 324 pixels in column order; 0 bright, 1 dark, 2 random, 3 pattern
    task automatic run_frame(input int mode);
        int mx;
        int sum;
        int v;
        int lim;
        int k;
        mx  = 0;
        sum = 0;
        k   = 0;
        lim = 40 + $unsigned($random(seed)) % 25;
        for (int n = 1; n <= 324; n++) begin
            case (mode)
                0: v = 63;
                1: v = 0;
                2: v = $unsigned($random(seed)) % lim;
                default: v = (n * 7) % 64;
            endcase
            if (v > mx) mx = v;
            sum += v;
            @(posedge clock_in);
            frame_start <= (n == 1);
            pix_valid   <= 1'b1;
            pix_value   <= 6'(v);
        end
        @(posedge clock_in);
        frame_start <= 1'b0;
        pix_valid   <= 1'b0;
        exp_model = agc_step(exp_model, mx, sum);
        while (exposure !== exp_model && k < 20) begin
            @(posedge clock_in);
            k++;
        end
        check("exposure after frame", exp_model, exposure);
        if (exposure !== exp_model) give_verdict();
    endtask

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        exp_model = EXP_RESET;
        repeat (6) @(posedge clock_in);
        check("exposure in reset", 16'h0100, exposure);
        check("sdio enable in reset", 16'h0001, {15'h0000, sdio_oe_n});
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        check_regs();
        u_ier_host_model.xfer(1'b0, ADDR_TYPE, 8'h00, d);
        check("type register", {8'h00, TYPE_RESERVED, ~TYPE_ID}, {8'h00, d});
        u_ier_host_model.xfer(1'b1, ADDR_EXP_LOW, 8'h3C, d);
        u_ier_host_model.xfer(1'b0, 7'h20, 8'h00, d);
        check("unmapped register", 16'h0000, {8'h00, d});
        check_regs();
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            if (i == 0 || i == 3) u_ier_host_model.xfer(1'b1, ADDR_PIXEL_DUMP, 8'($random(seed)), d);
            run_frame(3);
            u_ier_host_model.xfer(1'b0, ADDR_PIXEL_DUMP, 8'h00, d);
            check("dump byte", {8'h00, i == 0 || i == 3, 1'b1, 6'((i % 3 + 1) * 7)}, {8'h00, d});
            u_ier_host_model.xfer(1'b0, ADDR_PIXEL_DUMP, 8'h00, d);
            check("dump without frame", 16'h0000, {14'h0000, d[7:6]});
        end
        $display("test pixel dump done");
        old_exp = exp_model;
        fork
            begin
                repeat (230) @(posedge clock_in);
                u_ier_host_model.read_exposure(hi, lo);
            end
            run_frame(0);
        join
        check("captured pair", old_exp, {hi, lo});
        $display("test byte capture done");
        hold = 0;
        for (int f = 0; f < 80 && hold < 2; f++) begin
            run_frame(0);
            if (exp_model == EXP_MIN) hold++;
        end
        check("floor exposure", EXP_MIN, exposure);
        check_regs();
        $display("test bright surface done");
        hold = 0;
        for (int f = 0; f < 200 && hold < 2; f++) begin
            run_frame(1);
            if (exp_model == 16'(CAP)) hold++;
        end
        check("ceiling exposure", 16'h306D, exposure);
        check_regs();
        $display("test dark surface done");
        for (int f = 0; f < 12; f++) begin
            run_frame(2);
        end
        check_regs();
        $display("test random surface done");
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        check("exposure after reset", 16'h0100, exposure);
        rst_in <= 1'b0;
        $display("test second reset done");
        give_verdict();
    end
endmodule // testbench
